// ==== hw/acc_pkg.sv ====
/*
 * Shared constants and types for the converter control block.
 * Assumes a 25 MHz bus clock and a classic Wishbone register master.
 */
package acc_pkg;

   // Register byte offsets, one 32-bit word each
   localparam logic [7:0] OFS_SC1  = 8'h00;
   localparam logic [7:0] OFS_SC2  = 8'h04;
   localparam logic [7:0] OFS_RESH = 8'h08;
   localparam logic [7:0] OFS_RESL = 8'h0C;
   localparam logic [7:0] OFS_CVH  = 8'h10;
   localparam logic [7:0] OFS_CVL  = 8'h14;
   localparam logic [7:0] OFS_CFG  = 8'h18;

   // Field positions
   localparam int SC1_DONE  = 7;
   localparam int SC1_IEN   = 6;
   localparam int SC1_CONT  = 5;
   localparam int SC2_BUSY  = 7;
   localparam int SC2_HWTRG = 6;
   localparam int SC2_CMPEN = 5;
   localparam int SC2_CMPGT = 4;
   localparam int CFG_LP    = 7;
   localparam int CFG_DIV   = 5;
   localparam int CFG_LSMP  = 4;
   localparam int CFG_MODE  = 2;
   localparam logic [7:0] SC2_WMASK = 8'h70;

   // Values after reset
   localparam logic [7:0] SC1_RST = 8'h1F;
   localparam logic [7:0] CFG_RST = 8'h00;

   // Channel codes
   localparam logic [4:0] CH_LAST_EXT = 5'h1B;
   localparam logic [4:0] CH_RSVD     = 5'h1C;
   localparam logic [4:0] CH_REFH     = 5'h1D;
   localparam logic [4:0] CH_REFL     = 5'h1E;
   localparam logic [4:0] CH_OFF      = 5'h1F;

   // Resolution codes
   localparam logic [1:0] MODE_8  = 2'h0;
   localparam logic [1:0] MODE_12 = 2'h1;
   localparam logic [1:0] MODE_10 = 2'h2;

   // Sample period in conversion clock ticks
   localparam logic [4:0] SMP_SHORT = 5'h04;
   localparam logic [4:0] SMP_LONG  = 5'h14;

   typedef enum logic [1:0] {
      ACC_IDLE   = 2'b00,
      ACC_SAMPLE = 2'b01,
      ACC_CONV   = 2'b10
   } acc_state_t;

   // Wishbone request from the master
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [7:0]  adr;
      logic [31:0] dat;
   } acc_wb_req_t;

   typedef struct packed {
      logic [2:0] cnt;
      logic       tick;
   } acc_div_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] rdat;
      logic        irq;
      logic [7:0]  sc1;
      logic [7:0]  sc2;
      logic [7:0]  cvh;
      logic [7:0]  cvl;
      logic [7:0]  cfg;
      logic [11:0] res;
      acc_state_t  st;
      logic [4:0]  smp_cnt;
      logic [3:0]  bitn;
      logic [11:0] trial;
      logic        pwr;
      logic        sampling;
      logic        iso;
      logic        trg1;
      logic        trg2;
      logic        trg3;
   } acc_regs_t;

   localparam acc_regs_t REGS_RST = '{sc1: SC1_RST, cfg: CFG_RST, st: ACC_IDLE,
                                      iso: 1'b1, default: '0};

endpackage

// ==== hw/acc_clkdiv.sv ====
/*
 * Conversion clock divider: one-cycle tick every 1, 2, 4 or 8 clocks.
 * Assumes run_i stays high for the whole conversion it times.
 */
`timescale 1ns/1ps
`default_nettype none

module acc_clkdiv
   import acc_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Control
   input  wire logic       run_i,
   input  wire logic [1:0] ratio_i,
   // Tick out
   output logic            tick_o
);

   acc_div_t   q;
   acc_div_t   n;
   logic [2:0] lim;

   // Ratio code n divides by two to the n
   assign lim = 3'((4'h1 << ratio_i) - 4'h1);

   // Counter restarts whenever the converter idles
   always_comb begin
      n      = q;
      n.tick = 1'b0;
      if (!run_i) begin
         n.cnt = '0;
      end else if (q.cnt == lim) begin
         n.cnt  = '0;
         n.tick = 1'b1;
      end else begin
         n.cnt = q.cnt + 3'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign tick_o = q.tick;

endmodule

`default_nettype wire

// ==== hw/acc_top.sv ====
/*
 * Successive-approximation converter control with a Wishbone register slave.
 * Assumes an analog mux and a comparator/DAC core whose comparator output
 * is synchronous to clk_i and settles within one conversion clock tick.
 */
`timescale 1ns/1ps
`default_nettype none

module acc_top
   import acc_pkg::*;
(
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // Wishbone slave
   input  wire acc_wb_req_t  wb_i,
   output logic              wb_ack_o,
   output logic [31:0]       wb_dat_o,
   // Hardware trigger and interrupt
   input  wire logic         hw_trig_i,
   output logic              irq_o,
   // Analog core
   input  wire logic         comp_i,
   output logic [4:0]        mux_sel_o,
   output logic              mux_isolate_o,
   output logic              conv_power_o,
   output logic              sample_o,
   output logic [11:0]       dac_code_o
);

   acc_regs_t   q;
   acc_regs_t   n;
   logic        tick;
   logic        acc;
   logic        wr;
   logic        wr_sc1;
   logic        rd_resl;
   logic        hw_edge;
   logic        fin;
   logic        hit;
   logic        set_done;
   logic        go;
   logic [3:0]  nb;
   logic [11:0] t;
   logic [11:0] cv;
   logic [7:0]  rd;
   logic [1:0]  ratio;

   // Bits per result for the selected resolution
   function automatic logic [3:0] mode_bits(input logic [1:0] m);
      if (m == MODE_12) begin
         return 4'hC;
      end else if (m == MODE_10) begin
         return 4'hA;
      end else begin
         return 4'h8;
      end
   endfunction

   // Compare value assembled for the resolution in use
   function automatic logic [11:0] cmp_value(input logic [1:0] m,
                                             input logic [7:0] hi,
                                             input logic [7:0] lo);
      if (m == MODE_12) begin
         return {hi[3:0], lo};
      end else if (m == MODE_10) begin
         return {2'h0, hi[1:0], lo};
      end else begin
         return {4'h0, lo};
      end
   endfunction

   // Bus access takes effect on the edge that samples ack, one after the edge that presents it
   assign acc     = wb_i.cyc & wb_i.stb & q.ack;
   assign wr      = acc & wb_i.we & wb_i.sel[0];
   assign wr_sc1  = wr & (wb_i.adr == OFS_SC1);
   assign rd_resl = acc & ~wb_i.we & (wb_i.adr == OFS_RESL);
   assign nb      = mode_bits(q.cfg[CFG_MODE +: 2]);
   assign cv      = cmp_value(q.cfg[CFG_MODE +: 2], q.cvh, q.cvl);

   // Trigger edge only counts when armed and the converter is enabled
   assign hw_edge = q.trg2 & ~q.trg3 & q.sc2[SC2_HWTRG]
                    & (q.sc1[4:0] != CH_OFF);

   // Low power forbids the undivided clock, halving the top rate
   assign ratio = (q.cfg[CFG_LP] && q.cfg[CFG_DIV +: 2] == 2'h0) ? 2'h1
                  : q.cfg[CFG_DIV +: 2];

   acc_clkdiv u_div (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .run_i   (q.st != ACC_IDLE),
      .ratio_i (ratio),
      .tick_o  (tick)
   );

   // Next state of the whole block
   always_comb begin
      n        = q;
      fin      = 1'b0;
      hit      = 1'b0;
      set_done = 1'b0;
      go       = 1'b0;
      t        = q.trial;
      rd       = 8'h00;

      // Trigger synchroniser and edge history
      n.trg1 = hw_trig_i;
      n.trg2 = q.trg1;
      n.trg3 = q.trg2;

      // Ack one cycle after the request, dropped the cycle after
      n.ack = wb_i.cyc & wb_i.stb & ~q.ack;
      if (wb_i.adr == OFS_SC1) begin
         rd = q.sc1;
      end else if (wb_i.adr == OFS_SC2) begin
         rd = {q.st != ACC_IDLE, q.sc2[6:0]};
      end else if (wb_i.adr == OFS_RESH) begin
         rd = {4'h0, q.res[11:8]};
      end else if (wb_i.adr == OFS_RESL) begin
         rd = q.res[7:0];
      end else if (wb_i.adr == OFS_CVH) begin
         rd = q.cvh;
      end else if (wb_i.adr == OFS_CVL) begin
         rd = q.cvl;
      end else if (wb_i.adr == OFS_CFG) begin
         rd = q.cfg;
      end
      if (n.ack) begin
         n.rdat = {24'h0, rd};
      end

      // Sample then approximate, one step per conversion tick
      if (tick) begin
         case (q.st)
            ACC_SAMPLE: begin
               if (q.smp_cnt == 5'h01) begin
                  n.st          = ACC_CONV;
                  n.sampling    = 1'b0;
                  n.trial       = '0;
                  n.trial[nb - 4'h1] = 1'b1;
                  n.bitn        = nb - 4'h1;
               end else begin
                  n.smp_cnt = q.smp_cnt - 5'h01;
               end
            end
            ACC_CONV: begin
               // Comparator high keeps the trial bit
               if (!comp_i) begin
                  t[q.bitn] = 1'b0;
               end
               if (q.bitn == 4'h0) begin
                  fin = 1'b1;
               end else begin
                  t[q.bitn - 4'h1] = 1'b1;
                  n.bitn = q.bitn - 4'h1;
               end
               n.trial = t;
            end
            default: begin
            end
         endcase
      end

      // End of conversion: flag, result and what runs next
      if (fin) begin
         hit      = q.sc2[SC2_CMPGT] ? (t >= cv) : (t < cv);
         set_done = ~q.sc2[SC2_CMPEN] | hit;
         if (set_done) begin
            n.res = t;
         end
         if (q.sc1[SC1_CONT]) begin
            go = 1'b1;
         end else begin
            n.st  = ACC_IDLE;
            n.pwr = 1'b0;
         end
      end

      // Hardware start only from idle
      if (hw_edge && q.st == ACC_IDLE) begin
         go = 1'b1;
      end

      // Register writes; an SC1 write aborts any conversion in flight
      if (wr_sc1) begin
         n.sc1[6:0]  = wb_i.dat[6:0];
         n.st        = ACC_IDLE;
         n.pwr       = 1'b0;
         n.sampling  = 1'b0;
         // Off code or hardware mode: no conversion from this write
         go = (wb_i.dat[4:0] != CH_OFF) & ~q.sc2[SC2_HWTRG];
      end else if (wr && wb_i.adr == OFS_SC2) begin
         n.sc2 = wb_i.dat[7:0] & SC2_WMASK;
      end else if (wr && wb_i.adr == OFS_CVH) begin
         n.cvh = wb_i.dat[7:0];
      end else if (wr && wb_i.adr == OFS_CVL) begin
         n.cvl = wb_i.dat[7:0];
      end else if (wr && wb_i.adr == OFS_CFG) begin
         n.cfg = wb_i.dat[7:0];
      end

      // Start a sample period, length picked by the long sample bit
      if (go) begin
         n.st       = ACC_SAMPLE;
         n.pwr      = 1'b1;
         n.sampling = 1'b1;
         n.smp_cnt  = q.cfg[CFG_LSMP] ? SMP_LONG : SMP_SHORT;
      end

      // Completion beats a clear arriving in the same cycle
      n.sc1[SC1_DONE] = (q.sc1[SC1_DONE] & ~(wr_sc1 | rd_resl)) | set_done;
      n.irq = n.sc1[SC1_DONE] & n.sc1[SC1_IEN];

      // Reserved and unbonded codes pass straight to the mux
      n.iso = (n.sc1[4:0] == CH_OFF);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= REGS_RST;
      end else begin
         q <= n;
      end
   end

   // Outputs come straight from state flops
   assign wb_ack_o      = q.ack;
   assign wb_dat_o      = q.rdat;
   assign irq_o         = q.irq;
   assign mux_sel_o     = q.sc1[4:0];
   assign mux_isolate_o = q.iso;
   assign conv_power_o  = q.pwr;
   assign sample_o      = q.sampling;
   assign dac_code_o    = q.trial;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // Plain mode: every finish sets the flag
   chk_done_plain_set: assert property (
      fin && !q.sc2[SC2_CMPEN] |=> q.sc1[SC1_DONE])
      else $error("done flag missed after conversion");

   // Flag rises only from a qualifying finish
   chk_done_cmp_gate: assert property (
      !q.sc1[SC1_DONE] && !(fin && (!q.sc2[SC2_CMPEN] || hit)) |=> !q.sc1[SC1_DONE])
      else $error("done flag set without a true compare");

   chk_done_clear: assert property (
      (wr_sc1 || rd_resl) && !set_done |=> !q.sc1[SC1_DONE])
      else $error("done flag not cleared by access");

   chk_irq_tracks: assert property (
      irq_o == (q.sc1[SC1_DONE] && q.sc1[SC1_IEN]))
      else $error("interrupt does not follow flag and enable");

   chk_single_stop: assert property (
      fin && !q.sc1[SC1_CONT] && !wr_sc1 && !hw_edge
      |=> q.st == ACC_IDLE && !conv_power_o)
      else $error("single conversion left converter powered");

   chk_cont_restart: assert property (
      fin && q.sc1[SC1_CONT] && !wr_sc1 |=> q.st == ACC_SAMPLE && sample_o)
      else $error("continuous mode did not restart");

   chk_off_no_conv: assert property (
      wr_sc1 && wb_i.dat[4:0] == CH_OFF
      |=> (q.st == ACC_IDLE && !conv_power_o && mux_isolate_o)[*3])
      else $error("off code write started a conversion");

   chk_hw_start: assert property (
      hw_edge && q.st == ACC_IDLE && !wr_sc1 |=> q.st == ACC_SAMPLE ##1 conv_power_o)
      else $error("trigger edge did not start conversion");

   // A software start goes straight into the sample phase
   chk_sw_start: assert property (
      wr_sc1 && wb_i.dat[4:0] != CH_OFF && !q.sc2[SC2_HWTRG]
      |=> q.st == ACC_SAMPLE && conv_power_o && sample_o)
      else $error("software write did not start conversion");

   // The flag stands until software clears it
   chk_done_hold: assert property (
      q.sc1[SC1_DONE] && !wr_sc1 && !rd_resl |=> q.sc1[SC1_DONE])
      else $error("done flag dropped without a clear");

   // Enable low keeps the interrupt quiet whatever the flag does
   chk_irq_masked: assert property (
      !q.sc1[SC1_IEN] |-> !irq_o)
      else $error("interrupt raised while disabled");

   // Idle converter is never left powered or sampling
   chk_idle_unpowered: assert property (
      q.st == ACC_IDLE |-> !conv_power_o && !sample_o)
      else $error("idle converter still powered");

   // Low power must never run the undivided conversion clock
   chk_lp_divided: assert property (
      q.cfg[CFG_LP] |-> ratio != 2'h0)
      else $error("low power left the clock undivided");

   // In software mode a trigger edge must not wake the converter
   chk_sw_no_trigger: assert property (
      !q.sc2[SC2_HWTRG] && !wr_sc1 && q.st == ACC_IDLE |=> q.st == ACC_IDLE)
      else $error("converter started without a request");

   // Disabled channel code keeps the core off and quiet
   chk_off_isolated: assert property (
      mux_isolate_o |-> !conv_power_o && !sample_o)
      else $error("isolated input while converting");

   // Conversion clock stands still while idle, saving power
   chk_idle_no_tick: assert property (
      q.st == ACC_IDLE |=> !tick)
      else $error("conversion clock ticked while idle");

endmodule

`default_nettype wire

// ==== tb/acc_core_model.sv ====
/* Behavioural analog mux and comparator core for the converter bench.
   Assumes the control block drives sel, power and trial code from clk_i. */
`timescale 1ns/1ps
`default_nettype none

module acc_core_model
   import acc_pkg::*;
(
   // Clock
   input  wire logic        clk_i,
   // From the control block
   input  wire logic [4:0]  sel_i,
   input  wire logic        pwr_i,
   input  wire logic [11:0] dac_i,
   // Level of the external inputs
   input  wire logic [11:0] level_i,
   // Comparator
   output logic             comp_o
);
   logic        tog_q = 1'b0;
   logic [11:0] v;

   // Unpowered core gives a changing bit, so a held level cannot pass
   always_ff @(posedge clk_i) begin
      tog_q <= ~tog_q;
   end

   // References are full scale and ground; reserved codes read the pin level
   always_comb begin
      v = level_i;
      if (sel_i == CH_REFH) v = 12'hFFF;
      if (sel_i == CH_REFL) v = 12'h000;
      comp_o = pwr_i ? (v >= dac_i) : tog_q;
   end
endmodule

`default_nettype wire

// ==== tb/testbench.sv ====
/* Self-checking bench for the converter control block.
   Assumes acc_core_model on the analog side and a classic Wishbone master. */
`timescale 1ns/1ps
`default_nettype none

module testbench
   import acc_pkg::*;
;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   acc_wb_req_t wb = '0;
   logic        trg = 1'b0;
   logic [11:0] lvl = 12'h000;
   logic        ack, irq, comp, iso, pwr, smp;
   logic [31:0] rdat;
   logic [4:0]  msel;
   logic [11:0] dac;
   logic [7:0]  q;
   int          fail_count = 0;
   int          cmp_count = 0;
   logic [1:0]  mds [3] = '{MODE_8, MODE_10, MODE_12};

   always #20 clk_i = ~clk_i;

   acc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_ack_o(ack),
      .wb_dat_o(rdat), .hw_trig_i(trg), .irq_o(irq), .comp_i(comp),
      .mux_sel_o(msel), .mux_isolate_o(iso), .conv_power_o(pwr),
      .sample_o(smp), .dac_code_o(dac));
   acc_core_model i_core (.clk_i(clk_i), .sel_i(msel), .pwr_i(pwr),
      .dac_i(dac), .level_i(lvl), .comp_o(comp));

   // Expected result: references give full scale or zero; an input
   // above the top code of the resolution saturates there
   function automatic logic [11:0] expv(logic [4:0] c, logic [11:0] l,
                                        logic [1:0] m);
      logic [11:0] k;
      logic [11:0] v;
      k = (m == MODE_12) ? 12'hFFF : (m == MODE_10) ? 12'h3FF : 12'h0FF;
      v = l;
      if (c == CH_REFH) v = 12'hFFF;
      if (c == CH_REFL) v = 12'h000;
      return (v > k) ? k : v;
   endfunction

   // Compare outcome; high byte only counts in the wider modes
   function automatic logic cmpt(logic [11:0] r, logic [7:0] h, logic [7:0] l,
                                 logic [1:0] m, logic g);
      logic [11:0] v;
      v = {4'h0, l};
      if (m == MODE_12) v[11:8] = h[3:0];
      if (m == MODE_10) v[9:8] = h[1:0];
      return g ? (r >= v) : (r < v);
   endfunction

   // One classic cycle, held until ack is sampled high
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      wb <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: a, dat: {24'h0, d}};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 40);
      if (n >= 40) fail_count++;
      q = rdat[7:0];
      wb <= '0;
      @(posedge clk_i);
   endtask

   task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         $display("wrong value at %0t: %s", $time, m);
         fail_count++;
      end
   endtask

   // Waits out a conversion, counting sample cycles
   task automatic wait_idle(output int ns);
      int n;
      n = 0;
      ns = 0;
      do begin
         @(posedge clk_i);
         n++;
         if (smp === 1'b1) ns++;
      end while (pwr === 1'b1 && n < 3000);
   endtask

   // Polls the status register until the done flag shows
   task automatic poll();
      int n;
      n = 0;
      do begin
         bus(1'b0, OFS_SC1, 8'h00);
         n++;
      end while (q[7] !== 1'b1 && n < 200);
   endtask

   task automatic conclude();
      $display("%0d compares, %0d mismatches", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // Watchdog well beyond the expected run length
   initial begin
      repeat (60000) @(posedge clk_i);
      fail_count++;
      conclude();
   end

   initial begin
      int          ns, p, t;
      logic [4:0]  ch;
      logic [1:0]  md, dv;
      logic        lp, ls, g;
      logic [7:0]  ch_v, cl_v;
      logic [11:0] lv, e;
      void'($urandom(67));
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk(iso, 1'b1, "iso");
      bus(1'b0, OFS_SC1, 8'h00);
      chk(q, SC1_RST, "sc1");
      bus(1'b1, 8'h1C, 8'h5A);
      bus(1'b0, 8'h1C, 8'h00);
      chk(q, 8'h00, "unmapped");
      $display("test reset done");
      // Single conversions over modes, dividers and sample lengths
      for (int i = 0; i < 9; i++) begin
         md = mds[i % 3];
         dv = 2'($urandom_range(3));
         lp = 1'($urandom_range(1));
         ls = 1'($urandom_range(1));
         ch = (i == 7) ? CH_REFH : (i == 8) ? CH_REFL : 5'($urandom_range(27));
         lv = 12'($urandom);
         // Keep the level in range, bar one over-range corner
         if (i != 6) lv = lv & expv(CH_REFH, 12'h000, md);
         e = expv(ch, lv, md);
         lvl <= lv;
         bus(1'b1, OFS_CFG, {lp, dv, ls, md, 2'b00});
         bus(1'b1, OFS_SC1, {3'b010, ch});
         chk(msel, ch, "chan");
         wait_idle(ns);
         p = (lp && dv == 2'h0) ? 2 : (1 << dv);
         t = ls ? 20 * p : 4 * p;
         chk(ns >= t - p && ns <= t + p, 1'b1, "sample");
         bus(1'b0, OFS_SC1, 8'h00);
         chk(q[7], 1'b1, "done");
         chk(irq, 1'b1, "irq");
         bus(1'b0, OFS_RESH, 8'h00);
         chk(q, {4'h0, e[11:8]}, "resh");
         bus(1'b0, OFS_RESL, 8'h00);
         chk(q, e[7:0], "resl");
         bus(1'b0, OFS_SC1, 8'h00);
         chk(q[7], 1'b0, "rd clear");
         chk(pwr, 1'b0, "pwr");
      end
      $display("test single done");
      // Compare; first three rounds hit equality
      for (int i = 0; i < 9; i++) begin
         md = mds[i % 3];
         g = 1'($urandom_range(1));
         ch_v = 8'($urandom);
         cl_v = 8'($urandom);
         lv = (i < 3) ? ({ch_v[3:0], cl_v} & expv(CH_REFH, 12'h000, md))
                      : 12'($urandom);
         e = expv(5'h02, lv, md);
         lvl <= lv;
         bus(1'b1, OFS_SC2, {3'b001, g, 4'h0});
         bus(1'b1, OFS_CVH, ch_v);
         bus(1'b1, OFS_CVL, cl_v);
         bus(1'b1, OFS_CFG, {4'h0, md, 2'b00});
         bus(1'b1, OFS_SC1, 8'h42);
         wait_idle(ns);
         bus(1'b0, OFS_SC1, 8'h00);
         chk(q[7], cmpt(e, ch_v, cl_v, md, g), "cmp");
         chk(irq, q[7], "cmp irq");
         bus(1'b1, OFS_SC1, 8'h1F);
         bus(1'b0, OFS_SC1, 8'h00);
         chk(q[7], 1'b0, "wr clear");
      end
      $display("test compare done");
      // Continuous, then stopped by the all-ones code
      bus(1'b1, OFS_SC2, 8'h00);
      bus(1'b1, OFS_CFG, 8'h00);
      lvl <= 12'h0A5;
      bus(1'b1, OFS_SC1, 8'h23);
      poll();
      chk(irq, 1'b0, "masked");
      bus(1'b0, OFS_RESL, 8'h00);
      chk(q, 8'hA5, "cont");
      poll();
      chk(q[7], 1'b1, "again");
      bus(1'b1, OFS_SC1, 8'h3F);
      wait_idle(ns);
      repeat (300) @(posedge clk_i);
      chk({iso, pwr}, 2'b10, "off");
      bus(1'b0, OFS_SC1, 8'h00);
      chk(q[7], 1'b0, "extra");
      $display("test continuous done");
      // Hardware trigger gives one conversion
      bus(1'b1, OFS_SC2, 8'h40);
      bus(1'b1, OFS_SC1, 8'h47);
      repeat (100) @(posedge clk_i);
      chk(pwr, 1'b0, "no trig");
      trg <= 1'b1;
      repeat (4) @(posedge clk_i);
      trg <= 1'b0;
      poll();
      chk(irq, 1'b1, "trig");
      bus(1'b0, OFS_RESL, 8'h00);
      repeat (300) @(posedge clk_i);
      bus(1'b0, OFS_SC1, 8'h00);
      chk(q[7], 1'b0, "once");
      $display("test trigger done");
      conclude();
   end
endmodule

`default_nettype wire
